/* disk_cmd_defs.svh */
// Constants for the disk command decoder
// Functional notes
// - Class 1 opcode 00 is copy, the only class 1 opcode.
// - Six-byte copy: byte 4 count, byte 1 source unit, byte 5 destination unit.
// - Source address bytes 1-3, destination 5-7, byte 8 spare, 9 control.
// - Per sector read source, write destination, bump addresses, count down.
// - Twelve-byte copy: 24-bit count bytes 7-9; zero means 16,777,216 blocks.
// - Class 6 opcode 00: byte 2 zero sets track format, one double step.
// - Double step: byte 5 zero, byte 4 bit 0 enables or disables.
// - Double step lets a 96 TPI drive handle 48 TPI diskettes.
// - Codes 00/01: FM, 128-byte sectors, 16 per track, one/two sides.
// - Codes 06/07: first track FM 128 bytes, rest MFM 256 bytes, 16.
// - 86/87 256x16, 8A/8B 512x8, 8E/8F 1024x5, MFM, odd code two sides.
// - Reset format code is 8A; other variant would use 00.
// - Byte 2 sub-opcode: 0 track format, 1 double step, 2 defines minifloppy media.
// - Byte 3 bits 7-6 density: 00 192, 01 96, 10 48 TPI.
// - Byte 3 bit 5 sides, bit 4 recording density FM or MFM.
// - Byte 3 bits 1-0 sector size 128..1024; byte 4 sectors per track.
// - 192 TPI forces double sided MFM, ignoring bits 5-4.
// - Reset media is 192 TPI, 512-byte sectors, 17 per track.
// - Drive type needs a floppy unit; 2 means 8 ms step, 3 means 3 ms.
// - Reset drive type is the 8 ms stepping type.
`ifndef DISK_CMD_DEFS_SVH
`define DISK_CMD_DEFS_SVH
`define ADDR_CONTROL 12'h000
`define ADDR_STATUS 12'h004
`define ADDR_CMD_BASE 12'h010
`define ADDR_FORMAT 12'h040
`define ADDR_MEDIA 12'h044
`define ADDR_COPY_SRC 12'h048
`define ADDR_COPY_DST 12'h04C
`define ADDR_COPY_LEFT 12'h050
`define CMD_BYTES 12
`define CLASS_COPY 3'h1
`define CLASS_COPY_LONG 3'h5
`define CLASS_CONFIG 3'h6
`define OP_COPY 5'h00
`define OP_FORMAT 5'h00
`define OP_DRIVE_TYPE 5'h01
`define SUB_TRACK 8'h00
`define SUB_DSTEP 8'h01
`define SUB_MEDIA 8'h02
`define RESET_FORMAT 8'h8A
`define RESET_TPI 2'h0
`define RESET_SIZE 2'h2
`define RESET_SPT 8'h11
`define TYPE_8MS 8'h02
`define TYPE_3MS 8'h03
`define STEP_8MS_NS 8000000
`define STEP_3MS_NS 3000000
`define CLK_NS 25
`define STEP_8MS_CYC (`STEP_8MS_NS / `CLK_NS)
`define STEP_3MS_CYC (`STEP_3MS_NS / `CLK_NS)
`define ST_ERR_BIT 1
`define ST_BUSY_BIT 0
`endif

/* disk_cmd_pkg.sv */
// Types for the disk command decoder
package disk_cmd_pkg;
	typedef enum logic [2:0] {
		idle_state,
		decode_state,
		read_state,
		write_state,
		done_state
	} phase_type;

	typedef struct packed {
		logic [7:0] format_code;
		logic double_step;
		logic [1:0] tpi;
		logic two_sided;
		logic mfm;
		logic [1:0] size_code;
		logic [7:0] sectors_per_track;
		logic step_3ms;
	} config_type;

	typedef struct packed {
		logic [2:0] lun;
		logic [20:0] logical_block_address;
	} disk_addr_type;

	typedef struct packed {
		logic req;
		logic write;
		disk_addr_type addr;
	} sector_req_type;
endpackage

/* disk_command_decoder.sv */
// Disk command decoder with APB register access and copy sequencer
`timescale 1ns/1ps
`default_nettype none
`include "disk_cmd_defs.svh"
module disk_command_decoder
	import disk_cmd_pkg::*;
#(
	parameter int STEP_8MS_CYCLES = `STEP_8MS_CYC,
	parameter int STEP_3MS_CYCLES = `STEP_3MS_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] floppy_lun_mask,
	output sector_req_type sector_req,
	input wire logic sector_done,
	output config_type active_config,
	output logic [23:0] step_period_cycles
);

	typedef struct packed {
		logic [`CMD_BYTES*8-1:0] cmd;
		phase_type phase;
		config_type cfg;
		disk_addr_type src;
		disk_addr_type dst;
		logic [24:0] left;
		logic busy;
		logic err;
		logic [31:0] rdata;
		sector_req_type req;
	} state_type;

	state_type r;
	state_type next_r;

	function automatic logic [7:0] cmd_byte(input logic [95:0] c,
		input int idx);
		cmd_byte = c[idx*8 +: 8];
	endfunction

	function automatic disk_addr_type addr_inc(input disk_addr_type a);
		addr_inc.lun = a.lun;
		addr_inc.logical_block_address = a.logical_block_address + 21'd1;
	endfunction

	function automatic disk_addr_type addr_of(input logic [7:0] b2,
		input logic [7:0] b1, input logic [7:0] b0);
		addr_of.lun = b2[7:5];
		addr_of.logical_block_address = {b2[4:0], b1, b0};
	endfunction

	// Check that a track format code is one of the ten accepted codes
	function automatic logic format_ok(input logic [7:0] c);
		case (c)
			8'h00, 8'h01, 8'h06, 8'h07, 8'h86, 8'h87,
			8'h8A, 8'h8B, 8'h8E, 8'h8F: format_ok = 1'b1;
			default: format_ok = 1'b0;
		endcase
	endfunction

	function automatic config_type apply_format(input config_type c,
		input logic [7:0] code);
		config_type n;
		n = c;
		n.format_code = code;
		n.two_sided = code[0];
		n.tpi = 2'h1;
		case (code)
			8'h00, 8'h01: begin
				n.mfm = 1'b0;
				n.size_code = 2'h0;
				n.sectors_per_track = 8'd16;
			end
			// mixed first track; track zero rule lives in the formatter
			8'h06, 8'h07: begin
				n.mfm = 1'b1;
				n.size_code = 2'h1;
				n.sectors_per_track = 8'd16;
			end
			8'h86, 8'h87: begin
				n.mfm = 1'b1;
				n.size_code = 2'h1;
				n.sectors_per_track = 8'd16;
			end
			8'h8A, 8'h8B: begin
				n.mfm = 1'b1;
				n.size_code = 2'h2;
				n.sectors_per_track = 8'd8;
			end
			default: begin
				n.mfm = 1'b1;
				n.size_code = 2'h3;
				n.sectors_per_track = 8'd5;
			end
		endcase
		apply_format = n;
	endfunction

	// Command bytes sit one per byte address above the base
	function automatic logic in_cmd_window(input logic [11:0] a);
		in_cmd_window = a >= `ADDR_CMD_BASE &&
			a < `ADDR_CMD_BASE + 12'(`CMD_BYTES);
	endfunction

	function automatic int cmd_index(input logic [11:0] a);
		cmd_index = 32'(a - `ADDR_CMD_BASE);
	endfunction

	// zero count stands for the full 24-bit range
	function automatic logic [24:0] long_count(input logic [7:0] hi,
		input logic [7:0] mid, input logic [7:0] lo);
		if ({hi, mid, lo} == 24'h00_0000)
			long_count = 25'h100_0000;
		else
			long_count = {1'b0, hi, mid, lo};
	endfunction

	function automatic config_type apply_media(input config_type c,
		input logic [7:0] fmt, input logic [7:0] spt);
		config_type n;
		n = c;
		n.tpi = fmt[7:6];
		n.two_sided = fmt[5];
		n.mfm = fmt[4];
		n.size_code = fmt[1:0];
		n.sectors_per_track = spt;
		if (fmt[7:6] == 2'h0) begin
			n.two_sided = 1'b1;
			n.mfm = 1'b1;
		end
		apply_media = n;
	endfunction

	function automatic logic floppy_unit(input logic [7:0] lun_byte,
		input logic [3:0] mask);
		// Units above 3 have no mask bit, so they never qualify
		if (lun_byte[7])
			floppy_unit = 1'b0;
		else
			floppy_unit = mask[lun_byte[6:5]];
	endfunction

	function automatic sector_req_type sector_request(input logic wr,
		input disk_addr_type a);
		sector_request.req = 1'b1;
		sector_request.write = wr;
		sector_request.addr = a;
	endfunction

	// Unmapped offsets read as zero rather than erroring
	function automatic logic [31:0] read_word(input state_type s,
		input logic [11:0] a);
		read_word = 32'h0000_0000;
		case (a)
			`ADDR_STATUS: read_word = {30'h0, s.err, s.busy};
			`ADDR_FORMAT: read_word = {23'h0, s.cfg.double_step,
				s.cfg.format_code};
			`ADDR_MEDIA: read_word = {15'h0, s.cfg.step_3ms,
				s.cfg.sectors_per_track, 2'h0, s.cfg.tpi,
				s.cfg.two_sided, s.cfg.mfm, s.cfg.size_code};
			`ADDR_COPY_SRC: read_word = {8'h0, s.src};
			`ADDR_COPY_DST: read_word = {8'h0, s.dst};
			`ADDR_COPY_LEFT: read_word = {7'h0, s.left};
			default: begin
				if (in_cmd_window(a))
					read_word = {24'h00_0000,
						s.cmd[cmd_index(a) * 8 +: 8]};
			end
		endcase
	endfunction

	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	logic [7:0] b5;
	logic [7:0] b7;
	logic [7:0] b8;
	logic [7:0] b9;
	logic wr_fire;
	logic rd_fire;

	assign b0 = cmd_byte(r.cmd, 0);
	assign b1 = cmd_byte(r.cmd, 1);
	assign b2 = cmd_byte(r.cmd, 2);
	assign b3 = cmd_byte(r.cmd, 3);
	assign b4 = cmd_byte(r.cmd, 4);
	assign b5 = cmd_byte(r.cmd, 5);
	assign b7 = cmd_byte(r.cmd, 7);
	assign b8 = cmd_byte(r.cmd, 8);
	assign b9 = cmd_byte(r.cmd, 9);
	assign wr_fire = psel & penable & pwrite & clk_en;
	assign rd_fire = psel & ~pwrite;

	always_comb begin
		next_r = r;
		if (wr_fire) begin
			if (in_cmd_window(paddr))
				next_r.cmd[cmd_index(paddr) * 8 +: 8] = pwdata[7:0];
			// Start ignored while busy so a running copy keeps going
			if (paddr == `ADDR_CONTROL && pwdata[0] && !r.busy) begin
				next_r.phase = decode_state;
				next_r.busy = 1'b1;
				next_r.err = 1'b0;
			end
		end
		case (r.phase)
			idle_state: begin
			end
			decode_state: begin
				next_r.phase = done_state;
				if (b0[7:5] == `CLASS_COPY) begin
					if (b0[4:0] == `OP_COPY) begin
						next_r.src = addr_of(cmd_byte(r.cmd, 1),
							b2, b3);
						next_r.dst = addr_of(b5, cmd_byte(r.cmd, 6),
							cmd_byte(r.cmd, 7));
						next_r.left = {17'h0, b4};
						next_r.phase = (b4 == 8'h0) ? done_state :
							read_state;
					end else begin
						next_r.err = 1'b1;
					end
				end else if (b0[7:5] == `CLASS_COPY_LONG &&
					b0[4:0] == `OP_COPY) begin
					next_r.src = addr_of(cmd_byte(r.cmd, 1), b2, b3);
					next_r.dst = addr_of(b4, b5, cmd_byte(r.cmd, 6));
					next_r.left = long_count(b7, b8, b9);
					next_r.phase = read_state;
				end else if (b0[7:5] == `CLASS_CONFIG &&
					b0[4:0] == `OP_FORMAT) begin
					case (b2)
						`SUB_TRACK: begin
							if (format_ok(b5) && b4 == 8'h0)
								next_r.cfg = apply_format(r.cfg, b5);
							else
								next_r.err = 1'b1;
						end
						`SUB_DSTEP: begin
							if (b5 == 8'h0)
								next_r.cfg.double_step = b4[0];
							else
								next_r.err = 1'b1;
						end
						`SUB_MEDIA: begin
							if (b3[7:6] == 2'h3) begin
								next_r.err = 1'b1;
							end else begin
								next_r.cfg = apply_media(r.cfg, b3, b4);
							end
						end
						default: next_r.err = 1'b1;
					endcase
				end else if (b0[7:5] == `CLASS_CONFIG &&
					b0[4:0] == `OP_DRIVE_TYPE) begin
					if (!floppy_unit(b1, floppy_lun_mask))
						next_r.err = 1'b1;
					else if (b4 == `TYPE_8MS)
						next_r.cfg.step_3ms = 1'b0;
					else if (b4 == `TYPE_3MS)
						next_r.cfg.step_3ms = 1'b1;
					else
						next_r.err = 1'b1;
				end else begin
					next_r.err = 1'b1;
				end
			end
			read_state: begin
				next_r.req = sector_request(1'b0, r.src);
				if (r.req.req && sector_done) begin
					next_r.req.req = 1'b0;
					next_r.phase = write_state;
				end
			end
			write_state: begin
				next_r.req = sector_request(1'b1, r.dst);
				if (r.req.req && sector_done) begin
					next_r.req.req = 1'b0;
					next_r.src = addr_inc(r.src);
					next_r.dst = addr_inc(r.dst);
					next_r.left = r.left - 25'd1;
					next_r.phase = (r.left == 25'd1) ? done_state :
						read_state;
				end
			end
			done_state: begin
				next_r.busy = 1'b0;
				next_r.phase = idle_state;
			end
			default: next_r.phase = idle_state;
		endcase
		next_r.rdata = 32'h0000_0000;
		if (rd_fire)
			next_r.rdata = read_word(r, paddr);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
			r.phase <= idle_state;
			r.cfg.format_code <= `RESET_FORMAT;
			r.cfg.tpi <= `RESET_TPI;
			r.cfg.two_sided <= 1'b1;
			r.cfg.mfm <= 1'b1;
			r.cfg.size_code <= `RESET_SIZE;
			r.cfg.sectors_per_track <= `RESET_SPT;
			r.cfg.step_3ms <= 1'b0;
		end else if (clk_en) begin
			r <= next_r;
		end
	end

	// Read data registered in setup so access phase answers at once
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign prdata = r.rdata;
	assign sector_req = r.req;
	assign active_config = r.cfg;
	assign step_period_cycles = r.cfg.step_3ms ? 24'(STEP_3MS_CYCLES) :
		24'(STEP_8MS_CYCLES);

endmodule // disk_command_decoder
`default_nettype wire

/* disk_command_decoder_assertions.sv */
// Port checker for the disk command decoder
`timescale 1ns/1ps
`default_nettype none
module disk_command_decoder_checker
	import disk_cmd_pkg::*;
#(
	parameter int STEP_8MS_CYCLES = 8,
	parameter int STEP_3MS_CYCLES = 3
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic clk_en,
	input wire logic pready,
	input wire logic pslverr,
	input wire sector_req_type sector_req,
	input wire logic sector_done,
	input wire config_type active_config,
	input wire logic [23:0] step_period_cycles
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence read_done_s;
		clk_en && sector_req.req && !sector_req.write && sector_done;
	endsequence
	sequence write_issue_s;
		!sector_req.req ##[1:20] (sector_req.req && sector_req.write);
	endsequence
	a_step_period_map: assert property (
		step_period_cycles == (active_config.step_3ms ?
		STEP_3MS_CYCLES : STEP_8MS_CYCLES)) else $error("step period");
	a_reset_format: assert property (
		$rose(presetn) |-> active_config.format_code == 8'h8A)
		else $error("reset format");
	a_reset_media: assert property (
		$rose(presetn) |-> active_config.tpi == 2'h0 &&
		active_config.size_code == 2'h2 &&
		active_config.sectors_per_track == 8'h11 &&
		!active_config.step_3ms) else $error("reset media");
	a_tpi_legal: assert property (
		active_config.tpi != 2'h3) else $error("bad density");
	a_req_holds: assert property (
		sector_req.req && !sector_done |=> sector_req.req &&
		$stable(sector_req.addr)) else $error("request dropped");
	a_req_drops: assert property (
		clk_en && sector_req.req && sector_done |=> !sector_req.req)
		else $error("request held");
	a_read_write: assert property (
		read_done_s |=> write_issue_s) else $error("no write");
	a_ready_ok: assert property (
		pready && !pslverr) else $error("bus answer");
	a_freeze_hold: assert property (
		!clk_en |=> $stable(active_config) && $stable(sector_req))
		else $error("state moved");
endmodule // disk_command_decoder_checker
bind disk_command_decoder disk_command_decoder_checker #(
	.STEP_8MS_CYCLES(STEP_8MS_CYCLES),
	.STEP_3MS_CYCLES(STEP_3MS_CYCLES)
) checker_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
	.pready(pready), .pslverr(pslverr), .sector_req(sector_req),
	.sector_done(sector_done), .active_config(active_config),
	.step_period_cycles(step_period_cycles));
`default_nettype wire

/* drive_model.sv */
// Drive side model answering sector requests
`timescale 1ns/1ps
`default_nettype none
module drive_model
	import disk_cmd_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire sector_req_type sector_req,
	output logic sector_done
);
	logic [24:0] log_q [$];
	int wait_cnt;
	int served;
	// Every other sector answers slowly
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sector_done <= 1'b0;
			wait_cnt <= 0;
			served <= 0;
		end else if (sector_done) begin
			sector_done <= 1'b0;
		end else if (sector_req.req) begin
			if (wait_cnt == ((served % 2) ? 5 : 0)) begin
				sector_done <= 1'b1;
				wait_cnt <= 0;
				served <= served + 1;
				log_q.push_back({sector_req.write, sector_req.addr});
			end else begin
				wait_cnt <= wait_cnt + 1;
			end
		end
	end
endmodule // drive_model
`default_nettype wire

/* disk_command_decoder_test.sv */
// Testbench for the disk command decoder
`timescale 1ns/1ps
`default_nettype none
module disk_command_decoder_test
	import disk_cmd_pkg::*;
;
	logic pclk, presetn, clk_en, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic pready, pslverr, sector_done;
	logic [3:0] floppy_lun_mask;
	sector_req_type sector_req;
	config_type active_config;
	logic [23:0] step_period_cycles;
	int miscompares, samples_checked, cycles;
	logic [7:0] codes [10] = '{8'h00, 8'h01, 8'h06, 8'h07, 8'h86,
		8'h87, 8'h8A, 8'h8B, 8'h8E, 8'h8F};
	disk_command_decoder #(.STEP_8MS_CYCLES(8), .STEP_3MS_CYCLES(3))
	disk_command_decoder_inst (.pclk(pclk), .presetn(presetn),
		.clk_en(clk_en), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.floppy_lun_mask(floppy_lun_mask), .sector_req(sector_req),
		.sector_done(sector_done), .active_config(active_config),
		.step_period_cycles(step_period_cycles));
	drive_model drive_model_inst (.pclk(pclk), .presetn(presetn),
		.sector_req(sector_req), .sector_done(sector_done));
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	task automatic final_report();
		$display("checked %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	always @(posedge pclk) begin
		cycles <= cycles + 1;
		if (cycles == 8000) begin
			miscompares = miscompares + 1;
			final_report();
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked = samples_checked + 1;
		if (got !== exp) begin
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
			miscompares = miscompares + 1;
		end
	endtask
	// Caller is just past a rising edge; data taken as pready is sampled
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r);
		logic rdy;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			rdy = pready;
			r = prdata;
		end while (!rdy);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	task automatic cmd(input logic [0:11][7:0] b, input logic e);
		for (int n = 0; n < 12; n++)
			apb(1'b1, 12'h010 + 12'(n), {24'h0, b[n]}, q);
		apb(1'b1, 12'h000, 32'h0000_0001, q);
		repeat (2) @(posedge pclk);
		do apb(1'b0, 12'h004, 32'h0, q); while (q[0] !== 1'b0);
		chk({31'h0, q[1]}, {31'h0, e});
	endtask
	task automatic logchk(input logic [24:0] e);
		if (drive_model_inst.log_q.size() == 0)
			chk(32'h0, 32'hFFFF_FFFF);
		else
			chk({7'h0, drive_model_inst.log_q.pop_front()}, {7'h0, e});
	endtask
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{miscompares, samples_checked, cycles} = '0;
		clk_en = 1'b1;
		floppy_lun_mask = 4'hC;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		clk_en <= 1'b0;
		repeat (4) @(posedge pclk);
		clk_en <= 1'b1;
		rd(12'h040, 32'h0000_008A);
		rd(12'h044, 32'h0000_110E);
		chk({8'h0, step_period_cycles}, 32'h0000_0008);
		foreach (codes[i]) begin
			cmd({40'hC0_0000_0000, codes[i], 48'h0}, 1'b0);
			rd(12'h040, {24'h0, codes[i]});
		end
		cmd({40'hC0_0000_0000, 8'h02, 48'h0}, 1'b1);
		cmd({40'hC0_0000_0001, 8'h8A, 48'h0}, 1'b1);
		cmd({40'hC0_0001_0001, 8'h01, 48'h0}, 1'b1);
		rd(12'h040, 32'h0000_008F);
		cmd({40'hC0_0001_0001, 8'h00, 48'h0}, 1'b0);
		rd(12'h040, 32'h0000_018F);
		cmd({40'hC0_0001_0000, 8'h00, 48'h0}, 1'b0);
		rd(12'h040, 32'h0000_008F);
		cmd({48'hC000_0255_1E00, 48'h0}, 1'b0);
		rd(12'h044, 32'h0000_1E15);
		cmd({48'hC000_0203_0500, 48'h0}, 1'b0);
		rd(12'h044, 32'h0000_050F);
		cmd({48'hC000_02C0_0500, 48'h0}, 1'b1);
		cmd({48'hC000_0300_0000, 48'h0}, 1'b1);
		cmd({48'hC160_0000_0300, 48'h0}, 1'b0);
		chk({8'h0, step_period_cycles}, 32'h0000_0003);
		cmd({48'hC100_0000_0200, 48'h0}, 1'b1);
		cmd({48'hC160_0000_0400, 48'h0}, 1'b1);
		cmd({48'hC180_0000_0300, 48'h0}, 1'b1);
		rd(12'h044, 32'h0001_050F);
		cmd({48'hC140_0000_0200, 48'h0}, 1'b0);
		chk({8'h0, step_period_cycles}, 32'h0000_0008);
		cmd({48'h2100_0000_0000, 48'h0}, 1'b1);
		cmd({80'h2021_0005_0243_0010_0000, 16'h0}, 1'b0);
		logchk({1'b0, 3'h1, 21'h01_0005});
		logchk({1'b1, 3'h2, 21'h03_0010});
		logchk({1'b0, 3'h1, 21'h01_0006});
		logchk({1'b1, 3'h2, 21'h03_0011});
		rd(12'h050, 32'h0000_0000);
		cmd(96'hA021_0005_4300_1000_0001_0000, 1'b0);
		logchk({1'b0, 3'h1, 21'h01_0005});
		logchk({1'b1, 3'h2, 21'h03_0010});
		chk(32'(drive_model_inst.log_q.size()), 32'h0000_0000);
		final_report();
	end
endmodule // disk_command_decoder_test
`default_nettype wire
